// file: rbc_defs.svh
// Offsets, reset values and widths of the region bound and manual command registers
`ifndef RBC_DEFS_SVH
`define RBC_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RBC_OFF_R4_MIN_LO 12'h0C0
`define RBC_OFF_R4_MIN_HI 12'h0C4
`define RBC_OFF_R4_MAX_LO 12'h0C8
`define RBC_OFF_R4_MAX_HI 12'h0CC
`define RBC_OFF_R5_MIN_LO 12'h0D0
`define RBC_OFF_R5_MIN_HI 12'h004
`define RBC_OFF_R5_MAX_LO 12'h008
`define RBC_OFF_R5_MAX_HI 12'h00C
`define RBC_OFF_R6_MIN_LO 12'h0E0
`define RBC_OFF_R6_MIN_HI 12'h0E4
`define RBC_OFF_R6_MAX_LO 12'h0E8
`define RBC_OFF_R6_MAX_HI 12'h0EC
`define RBC_OFF_R7_MIN_LO 12'h0F0
`define RBC_OFF_R7_MIN_HI 12'h0F4
`define RBC_OFF_R7_MAX_LO 12'h0F8
`define RBC_OFF_R7_MAX_HI 12'h0FC
`define RBC_OFF_CHAN_LO 12'h100
`define RBC_OFF_CHAN_HI 12'h104
`define RBC_OFF_CMD_ADDR 12'h108
`define RBC_OFF_CMD_TRIG 12'h10C
`define RBC_OFF_RETRY 12'h110
// ----------------------------------------
// Reset values and field widths
// ----------------------------------------
`define RBC_RST_BOUND 32'h0000_0000
`define RBC_RST_CHAN_LO 32'h0000_0003
`define RBC_RST_CHAN_HI 32'h0000_0000
`define RBC_RST_CMD_ADDR 32'h0000_0000
`define RBC_RST_RETRY 32'h0000_0002
`define RBC_HI_BITS 16
`define RBC_NUM_WORDS 16
`define RBC_NUM_REGIONS 4
`endif

// file: rbc_pkg.sv
// Types shared by the region bound and manual command register slice
package rbc_pkg;
	// ----------------------------------------
	// Controller state, Gray coded along power-up path
	// ----------------------------------------
	typedef enum logic [2:0] {
		rbc_st_config = 3'h0,
		rbc_st_low_power = 3'h1,
		rbc_st_halted_state = 3'h3,
		rbc_st_ready = 3'h2,
		rbc_st_other = 3'h6
	} rbc_ctrl_state_t;
	// ----------------------------------------
	// Bundles
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [47:0] addr;
	} rbc_req_t;
	typedef struct packed {
		logic launch;
		logic [31:0] code;
		logic [31:0] addr;
	} rbc_cmd_t;
endpackage : rbc_pkg

// file: rbc_regs.sv
// Region bound registers, channel status and manual command launch
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`include "rbc_defs.svh"
module rbc_regs (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire rbc_pkg::rbc_ctrl_state_t ctrl_state,
	input wire logic [31:0] chan_status_lo,
	input wire logic [31:0] chan_status_hi,
	input wire rbc_pkg::rbc_req_t req,
	output logic [3:0] region_hit,
	output logic region_hit_valid,
	output rbc_pkg::rbc_cmd_t cmd,
	output logic [31:0] retry_policy
);
	// ----------------------------------------
	// Offsets of the bound words, four per region
	// ----------------------------------------
	localparam logic [11:0] BOUND_OFF [`RBC_NUM_WORDS] = '{
		`RBC_OFF_R4_MIN_LO, `RBC_OFF_R4_MIN_HI, `RBC_OFF_R4_MAX_LO, `RBC_OFF_R4_MAX_HI,
		`RBC_OFF_R5_MIN_LO, `RBC_OFF_R5_MIN_HI, `RBC_OFF_R5_MAX_LO, `RBC_OFF_R5_MAX_HI,
		`RBC_OFF_R6_MIN_LO, `RBC_OFF_R6_MIN_HI, `RBC_OFF_R6_MAX_LO, `RBC_OFF_R6_MAX_HI,
		`RBC_OFF_R7_MIN_LO, `RBC_OFF_R7_MIN_HI, `RBC_OFF_R7_MAX_LO, `RBC_OFF_R7_MAX_HI
	};

	logic [31:0] bound_ff [`RBC_NUM_WORDS];
	logic [31:0] chan_lo_ff;
	logic [31:0] chan_hi_ff;
	logic [31:0] cmd_addr_ff;
	logic [31:0] retry_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic cmd_launch_ff;
	logic [31:0] cmd_code_ff;
	logic [3:0] hit_ff;
	logic hit_valid_ff;
	logic [3:0] nxt_hit;
	logic wr_allowed;

	// ----------------------------------------
	// Write permission by controller state
	// ----------------------------------------
	// Only the command registers consult this; bounds and retry policy take writes in any state
	always_comb begin
		case (ctrl_state)
			rbc_pkg::rbc_st_config: wr_allowed = 1'b1;
			rbc_pkg::rbc_st_halted_state: wr_allowed = 1'b1;
			rbc_pkg::rbc_st_ready: wr_allowed = 1'b1;
			default: wr_allowed = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Bound words
	// ----------------------------------------
	// High words keep only bits 47:32; their upper half reads as zero
	genvar gi;
	generate
		for (gi = 0; gi < `RBC_NUM_WORDS; gi = gi + 1) begin : g_bound
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					bound_ff[gi] <= `RBC_RST_BOUND;
				end else if (reg_wr && reg_addr == BOUND_OFF[gi]) begin
					if (gi % 2 == 1) begin
						bound_ff[gi] <= {16'h0000, reg_wdata[15:0]};
					end else begin
						bound_ff[gi] <= reg_wdata;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Region compare on untranslated request address
	// ----------------------------------------
	generate
		for (gi = 0; gi < `RBC_NUM_REGIONS; gi = gi + 1) begin : g_hit
			logic [47:0] lo_bound;
			logic [47:0] hi_bound;
			assign lo_bound = {bound_ff[4*gi+1][15:0], bound_ff[4*gi]};
			assign hi_bound = {bound_ff[4*gi+3][15:0], bound_ff[4*gi+2]};
			assign nxt_hit[gi] = req.valid && req.addr >= lo_bound && req.addr <= hi_bound;
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hit_ff <= 4'h0;
			hit_valid_ff <= 1'b0;
		end else begin
			hit_ff <= nxt_hit;
			hit_valid_ff <= req.valid;
		end
	end

	// ----------------------------------------
	// Channel status, read-only copy of the controller's view
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_lo_ff <= `RBC_RST_CHAN_LO;
			chan_hi_ff <= `RBC_RST_CHAN_HI;
		end else begin
			chan_lo_ff <= chan_status_lo;
			chan_hi_ff <= chan_status_hi;
		end
	end

	// ----------------------------------------
	// Manual command address and retry policy
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_addr_ff <= `RBC_RST_CMD_ADDR;
		end else if (reg_wr && reg_addr == `RBC_OFF_CMD_ADDR && wr_allowed) begin
			cmd_addr_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			retry_ff <= `RBC_RST_RETRY;
		end else if (reg_wr && reg_addr == `RBC_OFF_RETRY) begin
			retry_ff <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Command launch
	// ----------------------------------------
	// The trigger holds no value; the launched code stands until the next launch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_launch_ff <= 1'b0;
			cmd_code_ff <= 32'h0000_0000;
		end else begin
			cmd_launch_ff <= reg_wr && reg_addr == `RBC_OFF_CMD_TRIG && wr_allowed;
			if (reg_wr && reg_addr == `RBC_OFF_CMD_TRIG && wr_allowed) begin
				cmd_code_ff <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Read path, data one cycle after the strobe
	// ----------------------------------------
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		for (int i = 0; i < `RBC_NUM_WORDS; i++) begin
			if (reg_addr == BOUND_OFF[i]) begin
				nxt_rdata = bound_ff[i];
			end
		end
		case (reg_addr)
			`RBC_OFF_CHAN_LO: nxt_rdata = chan_lo_ff;
			`RBC_OFF_CHAN_HI: nxt_rdata = chan_hi_ff;
			`RBC_OFF_CMD_ADDR: nxt_rdata = cmd_addr_ff;
			`RBC_OFF_CMD_TRIG: nxt_rdata = 32'h0000_0000;
			`RBC_OFF_RETRY: nxt_rdata = retry_ff;
			default: nxt_rdata = nxt_rdata;
		endcase
	end

	// Idle cycles return zero so a stale word never looks like a fresh answer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign region_hit = hit_ff;
	assign region_hit_valid = hit_valid_ff;
	assign cmd = '{launch: cmd_launch_ff, code: cmd_code_ff, addr: cmd_addr_ff};
	assign retry_policy = retry_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_bound_write: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_R6_MAX_LO && !wr_allowed
		|=> bound_ff[10] == $past(reg_wdata))
		else $error("bound word write lost");

	a_high_trunc: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_R5_MIN_HI
		|=> bound_ff[5] == {16'h0000, $past(reg_wdata[15:0])})
		else $error("high bound word not 16 bits");

	a_hit_region: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid && req.addr >= {bound_ff[1][15:0], bound_ff[0]}
		&& req.addr <= {bound_ff[3][15:0], bound_ff[2]}
		|=> region_hit[0] && region_hit_valid)
		else $error("region 4 hit missed");

	a_status_read: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rd && reg_addr == `RBC_OFF_CHAN_LO |=> reg_rdata == $past(chan_lo_ff))
		else $error("status low read wrong");

	a_status_ro: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_CHAN_HI |=> chan_hi_ff == $past(chan_status_hi))
		else $error("status word changed by write");

	a_addr_guard: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_CMD_ADDR && !wr_allowed |=> $stable(cmd.addr))
		else $error("command address written in barred state");

	a_trig_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_CMD_TRIG && wr_allowed
		|=> cmd.launch && cmd.code == $past(reg_wdata) ##1 !cmd.launch || $past(reg_wr))
		else $error("trigger did not launch one command");

	a_trig_refuse: assert property (@(posedge clk) disable iff (!reset_n)
		!(reg_wr && reg_addr == `RBC_OFF_CMD_TRIG && wr_allowed) |=> !cmd.launch)
		else $error("command launched without accepted write");

	a_trig_read: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rd && reg_addr == `RBC_OFF_CMD_TRIG |=> reg_rdata == 32'h0000_0000)
		else $error("trigger register readable");

	a_retry_any: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_RETRY |=> retry_policy == $past(reg_wdata))
		else $error("retry policy write lost");

	a_low_write: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_R4_MIN_LO
		|=> bound_ff[0] == $past(reg_wdata))
		else $error("low bound word write lost");

	a_high_keep: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_R7_MAX_HI
		|=> bound_ff[15] == {16'h0000, $past(reg_wdata[15:0])})
		else $error("upper bound high word not 16 bits");

	a_bound_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!reg_wr
		|=> $stable(bound_ff[10]))
		else $error("bound word changed without a write");

	a_bound_read: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rd && reg_addr == `RBC_OFF_R5_MIN_HI
		|=> reg_rdata == $past(bound_ff[5]))
		else $error("bound word read wrong");

	a_hit_idle: assert property (@(posedge clk) disable iff (!reset_n)
		!req.valid
		|=> region_hit == 4'h0 && !region_hit_valid)
		else $error("region hit without a request");

	a_hit_flag: assert property (@(posedge clk) disable iff (!reset_n)
		req.valid
		|=> region_hit_valid)
		else $error("request not flagged");

	a_status_follow: assert property (@(posedge clk) disable iff (!reset_n)
		reset_n
		|=> chan_lo_ff == $past(chan_status_lo) && chan_hi_ff == $past(chan_status_hi))
		else $error("status words not tracking the controller");

	a_addr_write: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == `RBC_OFF_CMD_ADDR && wr_allowed
		|=> cmd.addr == $past(reg_wdata))
		else $error("command address write lost");

	a_addr_read: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rd && reg_addr == `RBC_OFF_CMD_ADDR
		|=> reg_rdata == $past(cmd_addr_ff))
		else $error("command address read wrong");

	a_code_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!(reg_wr && reg_addr == `RBC_OFF_CMD_TRIG && wr_allowed)
		|=> $stable(cmd.code))
		else $error("command code changed without accepted trigger");

	a_retry_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!reg_wr
		|=> $stable(retry_policy))
		else $error("retry policy changed without a write");

	a_retry_read: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rd && reg_addr == `RBC_OFF_RETRY
		|=> reg_rdata == $past(retry_ff))
		else $error("retry policy read wrong");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!reset_n)
		!reg_rd
		|=> reg_rdata == 32'h0000_0000)
		else $error("read data outside its answer cycle");
endmodule : rbc_regs

// file: test_region_bounds_and_command_regs.sv
// Self-checking bench for the region bound and manual command register slice
`timescale 1ns/100ps
`include "rbc_defs.svh"
module test_region_bounds_and_command_regs;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk;
	logic reset_n;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	rbc_pkg::rbc_ctrl_state_t ctrl_state;
	logic [31:0] chan_status_lo;
	logic [31:0] chan_status_hi;
	rbc_pkg::rbc_req_t req;
	logic [3:0] region_hit;
	logic region_hit_valid;
	rbc_pkg::rbc_cmd_t cmd;
	logic [31:0] retry_policy;
	int error_cnt;
	int num_checks;
	logic [11:0] bo [16] = '{`RBC_OFF_R4_MIN_LO, `RBC_OFF_R4_MIN_HI, `RBC_OFF_R4_MAX_LO,
		`RBC_OFF_R4_MAX_HI, `RBC_OFF_R5_MIN_LO, `RBC_OFF_R5_MIN_HI, `RBC_OFF_R5_MAX_LO,
		`RBC_OFF_R5_MAX_HI, `RBC_OFF_R6_MIN_LO, `RBC_OFF_R6_MIN_HI, `RBC_OFF_R6_MAX_LO,
		`RBC_OFF_R6_MAX_HI, `RBC_OFF_R7_MIN_LO, `RBC_OFF_R7_MIN_HI, `RBC_OFF_R7_MAX_LO,
		`RBC_OFF_R7_MAX_HI};
	rbc_regs i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_state(ctrl_state),
		.chan_status_lo(chan_status_lo), .chan_status_hi(chan_status_hi), .req(req),
		.region_hit(region_hit), .region_hit_valid(region_hit_valid), .cmd(cmd),
		.retry_policy(retry_policy));
	always #5 clk = ~clk;
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so look there
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rdc
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 16; i++) rdc(bo[i], `RBC_RST_BOUND);
		rdc(`RBC_OFF_CHAN_LO, `RBC_RST_CHAN_LO);
		rdc(`RBC_OFF_CHAN_HI, `RBC_RST_CHAN_HI);
		rdc(`RBC_OFF_CMD_ADDR, `RBC_RST_CMD_ADDR);
		rdc(`RBC_OFF_RETRY, `RBC_RST_RETRY);
		chk(retry_policy, `RBC_RST_RETRY);
		$display("reset values done");
	endtask : t_reset
	// Low power forbids gated writes, yet bounds must still take writes
	task automatic t_bounds;
		@(posedge clk);
		ctrl_state <= rbc_pkg::rbc_st_low_power;
		for (int i = 0; i < 16; i++) wr(bo[i], 32'hA5C3_0F00 + i);
		for (int i = 0; i < 16; i++) rdc(bo[i], (i % 2) ? 32'h0F00 + i : 32'hA5C3_0F00 + i);
		$display("bound access done");
	endtask : t_bounds
	task automatic t_status;
		@(posedge clk);
		chan_status_lo <= 32'h1234_ABCD;
		chan_status_hi <= 32'h0000_00F0;
		wr(`RBC_OFF_CHAN_LO, 32'hFFFF_FFFF);
		wr(`RBC_OFF_CHAN_HI, 32'hFFFF_FFFF);
		rdc(`RBC_OFF_CHAN_LO, 32'h1234_ABCD);
		rdc(`RBC_OFF_CHAN_HI, 32'h0000_00F0);
		$display("status done");
	endtask : t_status
	task automatic t_gated;
		rbc_pkg::rbc_ctrl_state_t st [5] = '{rbc_pkg::rbc_st_config, rbc_pkg::rbc_st_low_power,
			rbc_pkg::rbc_st_halted_state, rbc_pkg::rbc_st_ready, rbc_pkg::rbc_st_other};
		logic [4:0] ok = 5'b01101;
		logic [31:0] ea = 32'h0;
		logic [31:0] ec = 32'h0;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			ctrl_state <= st[i];
			wr(`RBC_OFF_CMD_ADDR, 32'h0100_0000 + i);
			if (ok[i]) ea = 32'h0100_0000 + i;
			rdc(`RBC_OFF_CMD_ADDR, ea);
			chk(cmd.addr, ea);
			wr(`RBC_OFF_CMD_TRIG, 32'h00C0_0000 + i);
			if (ok[i]) ec = 32'h00C0_0000 + i;
			chk({31'h0, cmd.launch}, {31'h0, ok[i]});
			chk(cmd.code, ec);
			@(posedge clk);
			#1;
			chk({31'h0, cmd.launch}, 32'h0);
		end
		rdc(`RBC_OFF_CMD_TRIG, 32'h0);
		wr(`RBC_OFF_RETRY, 32'h0000_0005);
		rdc(`RBC_OFF_RETRY, 32'h0000_0005);
		chk(retry_policy, 32'h0000_0005);
		$display("gated writes done");
	endtask : t_gated
	// Region 4 spans 0x1_0000_1000..0x1_0000_2000; region 5 keeps its pattern bounds
	task automatic t_hit;
		logic [47:0] ha [7] = '{48'h1_0000_0FFF, 48'h1_0000_1000, 48'h1_0000_2000,
			48'h1_0000_2001, 48'h0_0000_1800, 48'h1_0000_1800, 48'h0F06_0000_0000};
		logic [3:0] eh [7] = '{4'h0, 4'h1, 4'h1, 4'h0, 4'h0, 4'h1, 4'h2};
		wr(`RBC_OFF_R4_MIN_LO, 32'h0000_1000);
		wr(`RBC_OFF_R4_MIN_HI, 32'h0000_0001);
		wr(`RBC_OFF_R4_MAX_LO, 32'h0000_2000);
		wr(`RBC_OFF_R4_MAX_HI, 32'h0000_0001);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			req <= '{valid: 1'b1, addr: ha[i]};
			@(posedge clk);
			req.valid <= 1'b0;
			#1;
			chk({28'h0, region_hit}, {28'h0, eh[i]});
			chk({31'h0, region_hit_valid}, 32'h1);
		end
		@(posedge clk);
		#1;
		chk({31'h0, region_hit_valid}, 32'h0);
		$display("region compare done");
	endtask : t_hit
	// A second reset must clear values that earlier scenarios left behind
	task automatic t_rerun;
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		#1;
		chk(retry_policy, `RBC_RST_RETRY);
		chk(cmd.code, 32'h0000_0000);
		chk(cmd.addr, `RBC_RST_CMD_ADDR);
		chk({28'h0, region_hit}, 32'h0);
		chk(reg_rdata, 32'h0000_0000);
		@(posedge clk);
		reset_n <= 1'b1;
		rdc(`RBC_OFF_R7_MAX_HI, `RBC_RST_BOUND);
		rdc(`RBC_OFF_RETRY, `RBC_RST_RETRY);
		rdc(`RBC_OFF_CHAN_LO, 32'h1234_ABCD);
		$display("mid-run reset done");
	endtask : t_rerun
	task automatic results;
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ctrl_state = rbc_pkg::rbc_st_config;
		chan_status_lo = `RBC_RST_CHAN_LO;
		chan_status_hi = `RBC_RST_CHAN_HI;
		req = '0;
		error_cnt = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_bounds;
		t_status;
		t_gated;
		t_hit;
		t_rerun;
		results;
	end
	initial begin
		#200000;
		error_cnt++;
		results;
	end
endmodule : test_region_bounds_and_command_regs
